// [include/pmic_regs_pkg.sv]
// Constants for the shutdown-cause and buck voltage register slice
package pmic_regs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_SHUTDOWN_CAUSE = 8'h05;
  localparam logic [7:0] OFF_BUCK_TWO_CODE  = 8'h21;
  localparam logic [7:0] OFF_BUCK_THREE_DEC = 8'h22;
  localparam logic [7:0] OFF_BUCK_THREE_VID = 8'h23;
  localparam logic [7:0] OFF_BUCK_THREE_SLP = 8'h24;

  // Reset values
  localparam logic [7:0] RST_SHUTDOWN_CAUSE = 8'h00;
  localparam logic [7:0] RST_BUCK_TWO_CODE  = 8'h50;
  localparam logic [7:0] RST_BUCK_THREE_DEC = 8'h70;
  localparam logic [7:0] RST_BUCK_THREE_VID = 8'h70;
  localparam logic [7:0] RST_BUCK_THREE_SLP = 8'h70;

  // Shutdown-cause bit positions
  localparam int unsigned BIT_OVERHEAT   = 0;
  localparam int unsigned BIT_RAIL_FAULT = 1;
  localparam int unsigned BIT_UNDERVOLT  = 2;
  localparam int unsigned BIT_PIN_OFF    = 3;
  localparam logic [7:0]  CAUSE_WMASK    = 8'h07;

  // Voltage code field in bits 7-1, decay/enable in bit 0
  localparam int unsigned CODE_LSB = 1;
  localparam int unsigned FLAG_BIT = 0;

  // Sync depth for pins
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// [include/pin_sync_if.sv]
// Interface carrying raw and synchronised event pins
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic [4:0] raw;
  logic [4:0] synced;
  modport src  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface
`default_nettype wire

// [hw/pin_sync.sv]
// Two-stage synchroniser for asynchronous event pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import pmic_regs_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst,
  pin_sync_if.sync    pins
);

  logic [4:0] meta_q;
  logic [4:0] meta_d;
  logic [4:0] stable_q;
  logic [4:0] stable_d;

  always_comb
  begin
    meta_d   = pins.raw;
    stable_d = meta_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q   <= 5'h0;
      stable_q <= 5'h0;
    end
    else
    begin
      meta_q   <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign pins.synced = stable_q;

endmodule
`default_nettype wire

// [hw/pmic_shutdown_regs.sv]
// Shutdown-cause and buck voltage-code register slice
//
// Overview of operation
// - Cause bits set only by device, cleared only by host writing one.
// - Pin-forced-off cause bit 3 always reads zero in this variant.
// - Undervoltage shutdown sets cause bit 2 and the shutdown flag.
// - Unmasked rail fault shutdown sets cause bit 1 and the shutdown flag.
// - Overheat shutdown sets cause bit 0 and the shutdown flag.
// - Buck two seven-bit voltage code in bits 7-1, reset 28h.
// - Buck two bit 0 picks active slew (0) or passive decay (1).
// - Buck three decay register bit 0 picks slew (0) or decay (1).
// - Buck three decay bits 7-1 read/write, reset 38h, no effect.
// - Buck three voltage code bits 7-1 reset 38h; bit 0 reserved RW.
// - Buck three sleep code reset 38h, copied to voltage code on sleep.
// - Sleep register bit 0 enables sleep change from factory-chosen pin.
// - Shutdown flag cleared by host only after cause bits are clear.
`timescale 1ns/1ps
`default_nettype none
module pmic_shutdown_regs
  import pmic_regs_pkg::*;
#(
  parameter bit SLEEP_PIN_SELECT = 1'b0
)
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic              irq_flag_clear,
  output logic                   shutdown_irq_flag,
  input  wire logic              undervoltage_event,
  input  wire logic              rail_fault_event,
  input  wire logic              overheat_event,
  input  wire logic              sleep_pin_a,
  input  wire logic              sleep_pin_b,
  output logic      [6:0]        reg_two_voltage_code,
  output logic                   reg_two_decay_select,
  output logic                   reg_three_decay_select,
  output logic      [6:0]        reg_three_voltage_code,
  output logic      [6:0]        reg_three_sleep_code,
  output logic                   reg_three_sleep_enable
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  pin_sync_if pins ();

  assign pins.raw = {sleep_pin_b, sleep_pin_a, overheat_event,
                     rail_fault_event, undervoltage_event};

  pin_sync u_sync
  (
    .clock (clock),
    .rst   (rst),
    .pins  (pins)
  );

  logic ev_uv;
  logic ev_rf;
  logic ev_ot;
  logic sleep_lvl;
  assign ev_uv     = pins.synced[0];
  assign ev_rf     = pins.synced[1];
  assign ev_ot     = pins.synced[2];
  assign sleep_lvl = SLEEP_PIN_SELECT ? pins.synced[4] : pins.synced[3];

  // ****************************************
  // Register state
  // ****************************************
  logic [DATA_W-1:0] cause_q, cause_d;
  logic [DATA_W-1:0] two_q, two_d;
  logic [DATA_W-1:0] dec_q, dec_d;
  logic [DATA_W-1:0] vid_q, vid_d;
  logic [DATA_W-1:0] slp_q, slp_d;
  logic              flag_q, flag_d;
  logic              sleep_q, sleep_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;

  function automatic logic hit(input logic [ADDR_W-1:0] off);
    hit = reg_wr_en && (reg_addr == off);
  endfunction

  logic [2:0] set_vec;
  logic       sleep_entry;
  assign set_vec     = {ev_uv, ev_rf, ev_ot};
  assign sleep_entry = sleep_lvl && !sleep_q && slp_q[FLAG_BIT];

  always_comb
  begin
    cause_d = cause_q;
    two_d   = two_q;
    dec_d   = dec_q;
    vid_d   = vid_q;
    slp_d   = slp_q;
    flag_d  = flag_q;
    sleep_d = sleep_lvl;
    // Host clears with ones in the low bits only
    if (hit(OFF_SHUTDOWN_CAUSE))
      cause_d = cause_q & ~(reg_wdata & CAUSE_WMASK);
    // Device sets win over a same-cycle clear
    cause_d[BIT_OVERHEAT]   = cause_d[BIT_OVERHEAT]   | ev_ot;
    cause_d[BIT_RAIL_FAULT] = cause_d[BIT_RAIL_FAULT] | ev_rf;
    cause_d[BIT_UNDERVOLT]  = cause_d[BIT_UNDERVOLT]  | ev_uv;
    cause_d[7:3]            = 5'h0;
    // Flag clear only with causes already clear
    if (irq_flag_clear && (cause_q[2:0] == 3'h0))
      flag_d = 1'b0;
    if (|set_vec)
      flag_d = 1'b1;
    if (hit(OFF_BUCK_TWO_CODE))
      two_d = reg_wdata;
    if (hit(OFF_BUCK_THREE_DEC))
      dec_d = reg_wdata;
    if (hit(OFF_BUCK_THREE_VID))
      vid_d = reg_wdata;
    if (hit(OFF_BUCK_THREE_SLP))
      slp_d = reg_wdata;
    // Sleep entry overrides a same-cycle host write of the code
    if (sleep_entry)
      vid_d[7:CODE_LSB] = slp_q[7:CODE_LSB];
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb
  begin
    rvalid_d = reg_rd_en;
    case (reg_addr)
      OFF_SHUTDOWN_CAUSE: rdata_d = cause_q;
      OFF_BUCK_TWO_CODE:  rdata_d = two_q;
      OFF_BUCK_THREE_DEC: rdata_d = dec_q;
      OFF_BUCK_THREE_VID: rdata_d = vid_q;
      OFF_BUCK_THREE_SLP: rdata_d = slp_q;
      default:            rdata_d = 8'h00;
    endcase
    if (!reg_rd_en)
      rdata_d = rdata_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cause_q  <= RST_SHUTDOWN_CAUSE;
      two_q    <= RST_BUCK_TWO_CODE;
      dec_q    <= RST_BUCK_THREE_DEC;
      vid_q    <= RST_BUCK_THREE_VID;
      slp_q    <= RST_BUCK_THREE_SLP;
      flag_q   <= 1'b0;
      sleep_q  <= 1'b0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      cause_q  <= cause_d;
      two_q    <= two_d;
      dec_q    <= dec_d;
      vid_q    <= vid_d;
      slp_q    <= slp_d;
      flag_q   <= flag_d;
      sleep_q  <= sleep_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign reg_rvalid             = rvalid_q;
  assign shutdown_irq_flag      = flag_q;
  assign reg_two_voltage_code   = two_q[7:CODE_LSB];
  assign reg_two_decay_select   = two_q[FLAG_BIT];
  assign reg_three_decay_select = dec_q[FLAG_BIT];
  assign reg_three_voltage_code = vid_q[7:CODE_LSB];
  assign reg_three_sleep_code   = slp_q[7:CODE_LSB];
  assign reg_three_sleep_enable = slp_q[FLAG_BIT];

  // ****************************************
  // Checks
  // ****************************************
  sequence s_cause_write_ones;
    reg_wr_en && (reg_addr == OFF_SHUTDOWN_CAUSE) && !(|set_vec);
  endsequence

  chk_pin_off_zero: assert property (@(posedge clock) disable iff (rst)
    cause_q[7:3] == 5'h0) else $error("cause upper bits nonzero");

  chk_uv_sets: assert property (@(posedge clock) disable iff (rst)
    ev_uv |=> cause_q[BIT_UNDERVOLT] && flag_q)
    else $error("undervoltage not recorded");

  chk_rf_sets: assert property (@(posedge clock) disable iff (rst)
    ev_rf |=> cause_q[BIT_RAIL_FAULT] && flag_q)
    else $error("rail fault not recorded");

  chk_ot_sets: assert property (@(posedge clock) disable iff (rst)
    ev_ot |=> cause_q[BIT_OVERHEAT] && flag_q)
    else $error("overheat not recorded");

  chk_cause_clear: assert property (@(posedge clock) disable iff (rst)
    s_cause_write_ones |=> cause_q[2:0] == ($past(cause_q[2:0])
      & ~$past(reg_wdata[2:0]))) else $error("cause clear wrong");

  chk_cause_hold: assert property (@(posedge clock) disable iff (rst)
    !(reg_wr_en && (reg_addr == OFF_SHUTDOWN_CAUSE))
      || (reg_wdata[2:0] == 3'h0)
      |=> (cause_q[2:0] & $past(cause_q[2:0])) == $past(cause_q[2:0]))
    else $error("cause bit lost without write");

  chk_flag_order: assert property (@(posedge clock) disable iff (rst)
    flag_q && irq_flag_clear && (cause_q[2:0] != 3'h0) |=> flag_q)
    else $error("flag cleared before causes");

  chk_sleep_copy: assert property (@(posedge clock) disable iff (rst)
    sleep_entry |=> vid_q[7:CODE_LSB] == $past(slp_q[7:CODE_LSB]))
    else $error("sleep code not copied");

  chk_sleep_gate: assert property (@(posedge clock) disable iff (rst)
    !slp_q[FLAG_BIT] && !(reg_wr_en && (reg_addr == OFF_BUCK_THREE_VID))
      |=> $stable(vid_q))
    else $error("code changed with sleep disabled");

endmodule
`default_nettype wire

// [tb/host_model.sv]
// Host side of the register port: byte writes, reads and flag clears
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clock,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            irq_flag_clear
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    irq_flag_clear = 1'b0;
  end
  // Called just after a falling edge; one-cycle strobes, one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clock);
    reg_rd_en = 1'b0;
    v = reg_rvalid;
    d = reg_rdata;
    @(negedge clock);
  endtask
  task automatic clr_flag;
    irq_flag_clear = 1'b1;
    @(negedge clock);
    irq_flag_clear = 1'b0;
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

// [tb/pmic_shutdown_and_buck_vid_regs_test.sv]
// Self-checking bench for the shutdown-cause and buck register slice
`timescale 1ns/1ps
`default_nettype none
module pmic_shutdown_and_buck_vid_regs_test;
  import pmic_regs_pkg::*;
  logic       clock, rst, wr_en, rd_en, rvalid, flag_clr, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] ev;
  logic       sp_a, sp_b, d2, d3, e3;
  logic [6:0] c2, c3, s3;
  int         error_cnt, samples_checked, flag_m;
  int         seed = 32'h5b33_b7d5;
  int         mdl [int];
  localparam logic [7:0] CA = OFF_SHUTDOWN_CAUSE;

  host_model i_host (.clock(clock), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(rvalid), .irq_flag_clear(flag_clr));
  pmic_shutdown_regs #(.SLEEP_PIN_SELECT(1'b0)) i_dut (
    .clock(clock), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(rvalid), .irq_flag_clear(flag_clr),
    .shutdown_irq_flag(irq), .undervoltage_event(ev[BIT_UNDERVOLT]),
    .rail_fault_event(ev[BIT_RAIL_FAULT]), .overheat_event(ev[BIT_OVERHEAT]),
    .sleep_pin_a(sp_a), .sleep_pin_b(sp_b), .reg_two_voltage_code(c2),
    .reg_two_decay_select(d2), .reg_three_decay_select(d3),
    .reg_three_voltage_code(c3), .reg_three_sleep_code(s3),
    .reg_three_sleep_enable(e3));

  // ***********************************************
  // Model, compare and helper tasks
  // ***********************************************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] m(input int a);
    return mdl.exists(a) ? 8'(mdl[a]) : 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d);
    if (a == CA)
      mdl[a] = m(a) & ~(d & CAUSE_WMASK);
    else if (mdl.exists(a))
      mdl[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    logic       v;
    i_host.rd(a, d, v);
    chk("rvalid", {7'h00, v}, 8'h01);
    chk($sformatf("reg %h", a), d, m(a));
  endtask
  task automatic clr;
    i_host.clr_flag();
    if ((m(CA) & 8'h07) == 0)
      flag_m = 0;
  endtask
  task automatic fields;
    chk("buck2", {c2, d2}, m(OFF_BUCK_TWO_CODE));
    chk("b3dec", {7'h00, d3}, m(OFF_BUCK_THREE_DEC) & 8'h01);
    chk("b3vid", {1'b0, c3}, m(OFF_BUCK_THREE_VID) >> 1);
    chk("b3slp", {s3, e3}, m(OFF_BUCK_THREE_SLP));
    chk("flag", {7'h00, irq}, 8'(flag_m));
  endtask
  // Cause bits 0..2 via events, 3 selected sleep pin, 4 unselected pin
  task automatic pulse(input int b);
    if (b < 3)
      ev[b] = 1'b1;
    else if (b == 3)
      sp_a = 1'b1;
    else
      sp_b = 1'b1;
    repeat (4) @(negedge clock);
    ev = 3'b000;
    sp_a = 1'b0;
    sp_b = 1'b0;
    repeat (3) @(negedge clock);
    if (b < 3)
    begin
      mdl[CA] = m(CA) | (1 << b);
      flag_m = 1;
    end
    else if (b == 3 && (m(OFF_BUCK_THREE_SLP) & 8'h01))
      mdl[OFF_BUCK_THREE_VID] = (m(OFF_BUCK_THREE_SLP) & 8'hfe)
                                | (m(OFF_BUCK_THREE_VID) & 8'h01);
    fields;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    summarize;
  end
  initial
  begin
    rst = 1'b1;
    ev = 3'b000;
    sp_a = 1'b0;
    sp_b = 1'b0;
    flag_m = 0;
    error_cnt = 0;
    samples_checked = 0;
    mdl[CA] = RST_SHUTDOWN_CAUSE;
    mdl[OFF_BUCK_TWO_CODE] = RST_BUCK_TWO_CODE;
    mdl[OFF_BUCK_THREE_DEC] = RST_BUCK_THREE_DEC;
    mdl[OFF_BUCK_THREE_VID] = RST_BUCK_THREE_VID;
    mdl[OFF_BUCK_THREE_SLP] = RST_BUCK_THREE_SLP;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    foreach (mdl[a]) rd(8'(a));
    wr(8'h06, 8'h5a);
    rd(8'h06);
    fields;
    wr(CA, 8'hff);
    rd(CA);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      rd(CA);
    end
    wr(CA, 8'hf8);
    rd(CA);
    clr;
    fields;
    wr(CA, 8'h02);
    rd(CA);
    wr(CA, 8'h05);
    clr;
    fields;
    repeat (4)
      for (int a = OFF_BUCK_TWO_CODE; a <= OFF_BUCK_THREE_SLP; a++)
      begin
        wr(8'(a), 8'($random(seed)));
        rd(8'(a));
      end
    fields;
    wr(OFF_BUCK_THREE_SLP, 8'($random(seed)) | 8'h01);
    pulse(3);
    rd(OFF_BUCK_THREE_VID);
    wr(OFF_BUCK_THREE_VID, 8'($random(seed)));
    pulse(4);
    wr(OFF_BUCK_THREE_SLP, 8'($random(seed)) & 8'hfe);
    pulse(3);
    rd(OFF_BUCK_THREE_VID);
    summarize;
  end
endmodule
`default_nettype wire
